// *** common/pbmc_pkg.sv ***
package pbmc_pkg;

  // Debounce interval in device clock cycles
  localparam int unsigned DEBOUNCE_INTERVAL_DEF = 32'd1000;
  // Global erase hold time
  localparam int unsigned GLOBAL_ERASE_MS       = 32'd3000;
  localparam int unsigned CLK_MHZ               = 32'd100;
  localparam int unsigned GLOBAL_ERASE_CYC      = GLOBAL_ERASE_MS * 32'd1000 * CLK_MHZ;
  localparam int unsigned PTR_W                 = 32'd4;
  localparam int unsigned PATH_CFG_W            = 32'd12;
  localparam int unsigned PATH_CFG_FT_BIT       = 32'd6;

  typedef enum logic [2:0] {
    PBMC_CMD_NONE,
    PBMC_CMD_PLAY,
    PBMC_CMD_RECORD,
    PBMC_CMD_ERASE_ONE,
    PBMC_CMD_ERASE_ALL,
    PBMC_CMD_FORWARD
  } pbmc_cmd_t;

  typedef struct packed {
    logic play;
    logic voice_capture_button_n;
    logic erase;
    logic next_message_button_n;
    logic ft;
  } pbmc_btn_t;

endpackage

// *** rtl/pbmc_debounce.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbmc_debounce
  import pbmc_pkg::*;
#(
  parameter int unsigned CNT_W  = 32,
  parameter logic        REL_DB = 1'b1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [CNT_W-1:0] interval,
  input  wire logic             raw_n,
  output logic                  clean_n
);
  logic [CNT_W-1:0] cnt_r;
  logic             state_r;
  wire              differ  = raw_n != state_r;
  wire              instant = raw_n && !REL_DB;
  wire              settled = cnt_r >= interval;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r   <= '0;
      state_r <= 1'b1;
    end else if (!differ) begin
      cnt_r <= '0;
    end else if (instant || settled) begin
      state_r <= raw_n;
      cnt_r   <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign clean_n = state_r;

  // A debounced change needs a full stable interval first, except a release when REL_DB is 0, which is taken at once
  a_db_settle: assert property (@(posedge clk) disable iff (rst)
    ($changed(state_r) && !(!REL_DB && state_r)) |-> $past(cnt_r) >= $past(interval))
    else $error("debounced level changed too early");
endmodule
`default_nettype wire

// *** rtl/pbmc_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbmc_control
  import pbmc_pkg::*;
#(
  parameter int unsigned DEBOUNCE_INTERVAL = DEBOUNCE_INTERVAL_DEF,
  parameter int unsigned ERASE_HOLD_CYC    = GLOBAL_ERASE_CYC,
  parameter int unsigned MSG_PTR_W         = PTR_W
) (
  input  wire logic                  REF_CLK,
  input  wire logic                  SYS_RST,
  input  wire logic                  PLAY_BUTTON_N,
  input  wire logic                  VOICE_CAPTURE_BUTTON_N,
  input  wire logic                  ERASE_BUTTON_N,
  input  wire logic                  NEXT_MESSAGE_BUTTON_N,
  input  wire logic                  PASSTHROUGH_REQUEST_N,
  input  wire logic                  SERIAL_MODE,
  input  wire logic [PATH_CFG_W-1:0] PATH_CONFIG_REG,
  input  wire logic                  SERIAL_CMD_DONE,
  input  wire logic                  SERIAL_INT_CLEAR,
  input  wire logic                  MESSAGE_END,
  input  wire logic                  OP_DONE,
  input  wire logic [MSG_PTR_W-1:0]  MESSAGE_COUNT,
  output logic                       RDY_INT_OE,
  output logic                       RDY_INT_O,
  output logic                       PASSTHROUGH_EN,
  output logic [2:0]                 OP_CMD,
  output logic                       OP_START,
  output logic                       OP_STOP,
  output logic [MSG_PTR_W-1:0]       PLAY_POINTER
);
  typedef enum logic [2:0] {
    PBMC_IDLE,
    PBMC_PLAYING,
    PBMC_RECORDING,
    PBMC_ERASE_WAIT,
    PBMC_ERASING,
    PBMC_FORWARDING
  } pbmc_state_t;

  localparam int unsigned CNT_W = 32;
  localparam logic [CNT_W-1:0] DB_CYC    = CNT_W'(DEBOUNCE_INTERVAL);
  localparam logic [CNT_W-1:0] ERASE_CYC = CNT_W'(ERASE_HOLD_CYC);

  pbmc_btn_t   raw_n, clean_n, prev_n_r;
  pbmc_state_t state_r, state_nxt;
  logic [CNT_W-1:0]     hold_r;
  logic [MSG_PTR_W-1:0] ptr_r, ptr_nxt;
  logic                 int_r, rdy_oe_r, ft_r, start_r, stop_r;
  logic [2:0]           cmd_r, cmd_nxt;
  logic                 start_nxt, stop_nxt;

  assign raw_n = '{play: PLAY_BUTTON_N, voice_capture_button_n: VOICE_CAPTURE_BUTTON_N, erase: ERASE_BUTTON_N,
                   next_message_button_n: NEXT_MESSAGE_BUTTON_N, ft: PASSTHROUGH_REQUEST_N};

  pbmc_debounce #(.CNT_W(CNT_W), .REL_DB(1'b1)) u_db_play (.clk(REF_CLK), .rst(SYS_RST),
    .interval(DB_CYC), .raw_n(raw_n.play), .clean_n(clean_n.play));
  pbmc_debounce #(.CNT_W(CNT_W), .REL_DB(1'b0)) u_db_rec (.clk(REF_CLK), .rst(SYS_RST),
    .interval(DB_CYC), .raw_n(raw_n.voice_capture_button_n), .clean_n(clean_n.voice_capture_button_n));
  pbmc_debounce #(.CNT_W(CNT_W), .REL_DB(1'b1)) u_db_erase (.clk(REF_CLK), .rst(SYS_RST),
    .interval(DB_CYC), .raw_n(raw_n.erase), .clean_n(clean_n.erase));
  pbmc_debounce #(.CNT_W(CNT_W), .REL_DB(1'b1)) u_db_fwd (.clk(REF_CLK), .rst(SYS_RST),
    .interval(DB_CYC), .raw_n(raw_n.next_message_button_n), .clean_n(clean_n.next_message_button_n));
  pbmc_debounce #(.CNT_W(CNT_W), .REL_DB(1'b1)) u_db_ft (.clk(REF_CLK), .rst(SYS_RST),
    .interval(DB_CYC), .raw_n(raw_n.ft), .clean_n(clean_n.ft));

  // Press events from debounced levels
  wire standalone  = !SERIAL_MODE;
  wire play_press  = standalone && prev_n_r.play && !clean_n.play;
  wire rec_press   = standalone && prev_n_r.voice_capture_button_n && !clean_n.voice_capture_button_n;
  wire erase_press = standalone && prev_n_r.erase && !clean_n.erase;
  wire erase_rel   = clean_n.erase;
  wire fwd_press   = standalone && prev_n_r.next_message_button_n && !clean_n.next_message_button_n;
  wire play_held   = !clean_n.play;
  wire hold_done   = hold_r >= ERASE_CYC;
  wire [MSG_PTR_W-1:0] last_msg = (MESSAGE_COUNT == '0) ? '0 : MESSAGE_COUNT - 1'b1;
  wire at_edge_msg = (ptr_r == '0) || (ptr_r == last_msg);
  wire [MSG_PTR_W-1:0] ptr_next = (ptr_r >= last_msg) ? '0 : ptr_r + 1'b1;

  always_comb begin
    state_nxt = state_r;
    ptr_nxt   = ptr_r;
    cmd_nxt   = cmd_r;
    start_nxt = 1'b0;
    stop_nxt  = 1'b0;
    case (state_r)
      PBMC_IDLE: begin
        if (rec_press) begin
          state_nxt = PBMC_RECORDING;
          cmd_nxt   = PBMC_CMD_RECORD;
          start_nxt = 1'b1;
        end else if (play_press) begin
          state_nxt = PBMC_PLAYING;
          cmd_nxt   = PBMC_CMD_PLAY;
          start_nxt = 1'b1;
        end else if (erase_press && at_edge_msg) begin
          state_nxt = PBMC_ERASE_WAIT;
        end else if (fwd_press) begin
          state_nxt = PBMC_FORWARDING;
          ptr_nxt   = ptr_next;
          cmd_nxt   = PBMC_CMD_FORWARD;
          start_nxt = 1'b1;
        end
      end
      PBMC_PLAYING: begin
        if (fwd_press) begin
          ptr_nxt   = ptr_next;
          start_nxt = 1'b1;
          stop_nxt  = 1'b1;
        end else if (play_press) begin
          state_nxt = PBMC_IDLE;
          stop_nxt  = 1'b1;
        end else if (MESSAGE_END && play_held) begin
          ptr_nxt   = ptr_next;
          start_nxt = 1'b1;
        end else if (MESSAGE_END) begin
          state_nxt = PBMC_IDLE;
        end
      end
      PBMC_RECORDING: begin
        if (clean_n.voice_capture_button_n || SERIAL_MODE) begin
          state_nxt = PBMC_IDLE;
          stop_nxt  = 1'b1;
        end
      end
      PBMC_ERASE_WAIT: begin
        if (hold_done) begin
          state_nxt = PBMC_ERASING;
          cmd_nxt   = PBMC_CMD_ERASE_ALL;
          start_nxt = 1'b1;
          ptr_nxt   = '0;
        end else if (erase_rel) begin
          state_nxt = PBMC_ERASING;
          cmd_nxt   = PBMC_CMD_ERASE_ONE;
          start_nxt = 1'b1;
        end
      end
      PBMC_ERASING, PBMC_FORWARDING: begin
        if (OP_DONE) begin
          state_nxt = PBMC_IDLE;
        end
      end
      default: state_nxt = PBMC_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r  <= PBMC_IDLE;
      prev_n_r <= '1;
      hold_r   <= '0;
      ptr_r    <= '0;
      cmd_r    <= PBMC_CMD_NONE;
      start_r  <= 1'b0;
      stop_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      prev_n_r <= clean_n;
      hold_r   <= (state_r == PBMC_ERASE_WAIT) ? hold_r + 1'b1 : '0;
      ptr_r    <= ptr_nxt;
      cmd_r    <= cmd_nxt;
      start_r  <= start_nxt;
      stop_r   <= stop_nxt;
    end
  end

  // Open-drain ready/interrupt pin; set wins over clear
  wire busy    = state_nxt != PBMC_IDLE;
  wire int_nxt = SERIAL_CMD_DONE || (int_r && !SERIAL_INT_CLEAR);
  wire ft_cfg  = PATH_CONFIG_REG[PATH_CFG_FT_BIT];

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      int_r    <= 1'b0;
      rdy_oe_r <= 1'b0;
      ft_r     <= 1'b0;
    end else begin
      int_r    <= SERIAL_MODE && int_nxt;
      rdy_oe_r <= SERIAL_MODE ? int_nxt : busy;
      ft_r     <= SERIAL_MODE ? ft_cfg : !clean_n.ft;
    end
  end

  assign RDY_INT_OE     = rdy_oe_r;
  assign RDY_INT_O      = 1'b0;
  assign PASSTHROUGH_EN = ft_r;
  assign OP_CMD         = cmd_r;
  assign OP_START       = start_r;
  assign OP_STOP        = stop_r;
  assign PLAY_POINTER   = ptr_r;

  a_play_starts: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state_r == PBMC_IDLE && play_press && !rec_press) |=> (state_r == PBMC_PLAYING && OP_START))
    else $error("play press did not start playback");
  a_play_ends: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state_r == PBMC_PLAYING && MESSAGE_END && !play_held && !fwd_press && !play_press)
    |=> state_r == PBMC_IDLE)
    else $error("playback did not end at message end");
  a_play_stop: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state_r == PBMC_PLAYING && play_press && !fwd_press) |=> (state_r == PBMC_IDLE && OP_STOP))
    else $error("second play press did not stop");
  a_play_loop: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state_r == PBMC_PLAYING && MESSAGE_END && play_held && !fwd_press)
    |=> (state_r == PBMC_PLAYING && OP_START && PLAY_POINTER != $past(PLAY_POINTER, 1)
         || MESSAGE_COUNT <= 1))
    else $error("held play did not loop");
  a_rec_stop: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state_r == PBMC_RECORDING && clean_n.voice_capture_button_n) |=> (state_r == PBMC_IDLE && OP_STOP))
    else $error("record release did not stop");
  a_erase_gate: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state_r == PBMC_IDLE && erase_press && !at_edge_msg) |=> state_r != PBMC_ERASE_WAIT)
    else $error("erase accepted away from first or last message");
  a_global_erase: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state_r == PBMC_ERASE_WAIT && hold_done) |=> (OP_CMD == PBMC_CMD_ERASE_ALL && OP_START))
    else $error("long erase hold did not erase all");
  a_fwd_restart: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (state_r == PBMC_PLAYING && fwd_press) |=> (OP_STOP && OP_START && state_r == PBMC_PLAYING))
    else $error("forward during playback did not restart");
  a_ready_low: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (!SERIAL_MODE && state_r != PBMC_IDLE) |-> RDY_INT_OE)
    else $error("ready not driven low while busy");
  a_int_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (SERIAL_MODE && SERIAL_CMD_DONE) ##1 (SERIAL_MODE && !SERIAL_INT_CLEAR)[*2] |-> RDY_INT_OE)
    else $error("interrupt released before clear");

  // Record start: press seen in idle, then command launched
  sequence s_rec_press_idle;
    state_r == PBMC_IDLE && rec_press;
  endsequence
  sequence s_rec_launched;
    state_r == PBMC_RECORDING && OP_START && OP_CMD == PBMC_CMD_RECORD;
  endsequence
  a_rec_start: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_rec_press_idle |=> s_rec_launched)
    else $error("record press did not start recording");

  // Record release: raw high, no debounce, stop two edges later
  sequence s_rec_raw_release;
    state_r == PBMC_RECORDING && VOICE_CAPTURE_BUTTON_N && !clean_n.voice_capture_button_n;
  endsequence
  a_rec_fast_stop: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_rec_raw_release |-> ##2 OP_STOP)
    else $error("record release was delayed");

  // Short erase: release before the hold limit erases one message
  sequence s_erase_short;
    state_r == PBMC_ERASE_WAIT && !hold_done && erase_rel;
  endsequence
  a_erase_one: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_erase_short |=> (OP_CMD == PBMC_CMD_ERASE_ONE && OP_START))
    else $error("short erase did not erase one message");

  // Forward in idle moves the pointer on by one, wrapping to 0 after the last message
  sequence s_fwd_idle;
    state_r == PBMC_IDLE && fwd_press && !rec_press && !play_press && !erase_press;
  endsequence
  a_fwd_idle: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_fwd_idle |=> (state_r == PBMC_FORWARDING && PLAY_POINTER == $past(ptr_next)))
    else $error("forward in idle did not advance");

  a_ready_release: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (!SERIAL_MODE && !$past(SERIAL_MODE) && state_r == PBMC_IDLE) |-> !RDY_INT_OE)
    else $error("ready held low while idle");
  a_int_clear: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (SERIAL_MODE && SERIAL_INT_CLEAR && !SERIAL_CMD_DONE) |=> !RDY_INT_OE)
    else $error("interrupt not released on clear");
  a_ft_pin: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !SERIAL_MODE |=> (PASSTHROUGH_EN == !$past(clean_n.ft)))
    else $error("passthrough does not follow pin");
  a_ft_config: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    SERIAL_MODE |=> (PASSTHROUGH_EN == $past(ft_cfg)))
    else $error("passthrough does not follow config bit");
endmodule
`default_nettype wire

// *** testbench/pbmc_store_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbmc_store_model
  import pbmc_pkg::*;
#(
  parameter int unsigned PLAY_LEN = 60
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       op_start,
  input  wire logic [2:0] op_cmd,
  output logic            message_end,
  output logic            op_done
);
  int unsigned play_cnt;
  int unsigned op_cnt;
  // Answers at the falling edge, like the bench
  always @(negedge clk or posedge rst) begin
    message_end <= 1'b0;
    op_done     <= 1'b0;
    if (rst) begin
      play_cnt <= 0;
      op_cnt   <= 0;
    end else if (op_start && op_cmd == PBMC_CMD_PLAY) begin
      play_cnt <= PLAY_LEN;
    end else if (op_start && op_cmd != PBMC_CMD_RECORD) begin
      op_cnt <= 5;
    end else begin
      if (play_cnt == 1) message_end <= 1'b1;
      if (op_cnt == 1) op_done <= 1'b1;
      if (play_cnt != 0) play_cnt <= play_cnt - 1;
      if (op_cnt != 0) op_cnt <= op_cnt - 1;
    end
  end
endmodule
`default_nettype wire

// *** testbench/pushbutton_message_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module pushbutton_message_control_bench;
  import pbmc_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, play_n = 1'b1, rec_n = 1'b1, erase_n = 1'b1, fwd_n = 1'b1, pt_n = 1'b1;
  logic serial = 1'b0, cmd_done = 1'b0, int_clr = 1'b0;
  logic [PATH_CFG_W-1:0] cfg = 12'h000;
  logic [3:0] msg_cnt = 4'h4;
  logic msg_end, op_done, oe, od, pt_en, op_start, op_stop;
  logic [2:0] op_cmd, last_cmd;
  logic [3:0] ptr;
  int fails = 0, n_tests = 0, n_start = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (op_start === 1'b1) begin n_start++; last_cmd <= op_cmd; end
    if (cyc == 20000) begin fails++; final_report(); end
  end
  pbmc_control #(.DEBOUNCE_INTERVAL(4), .ERASE_HOLD_CYC(50), .MSG_PTR_W(4)) pbmc_control_inst (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .PLAY_BUTTON_N(play_n), .VOICE_CAPTURE_BUTTON_N(rec_n),
    .ERASE_BUTTON_N(erase_n), .NEXT_MESSAGE_BUTTON_N(fwd_n), .PASSTHROUGH_REQUEST_N(pt_n),
    .SERIAL_MODE(serial), .PATH_CONFIG_REG(cfg), .SERIAL_CMD_DONE(cmd_done), .SERIAL_INT_CLEAR(int_clr),
    .MESSAGE_END(msg_end), .OP_DONE(op_done), .MESSAGE_COUNT(msg_cnt), .RDY_INT_OE(oe), .RDY_INT_O(od),
    .PASSTHROUGH_EN(pt_en), .OP_CMD(op_cmd), .OP_START(op_start), .OP_STOP(op_stop), .PLAY_POINTER(ptr));
  pbmc_store_model pbmc_store_model_inst (.clk(ref_clk), .rst(sys_rst), .op_start(op_start),
    .op_cmd(op_cmd), .message_end(msg_end), .op_done(op_done));
  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wait_starts(input int n);
    for (int i = 0; i < 100 && n_start < n; i++) @(negedge ref_clk);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 300 && oe !== 1'b0; i++) @(negedge ref_clk);
  endtask
  task automatic t_play();
    int s;
    s = n_start;
    play_n = 1'b0; cycles(2); play_n = 1'b1; cycles(20);
    `CHK("glitch", s, n_start)
    play_n = 1'b0; cycles(10); play_n = 1'b1; wait_starts(s + 1); cycles(1);
    `CHK("play cmd", PBMC_CMD_PLAY, last_cmd)
    `CHK("rdy busy", 1'b1, oe)
    fwd_n = 1'b0; cycles(10); fwd_n = 1'b1; wait_starts(s + 2); cycles(1);
    `CHK("restart cmd", PBMC_CMD_PLAY, last_cmd)
    `CHK("restart ptr", 4'h1, ptr)
    wait_idle();
    `CHK("play end", 1'b0, oe)
  endtask
  task automatic t_rec();
    int i;
    rec_n = 1'b0; wait_starts(n_start + 1); cycles(1);
    `CHK("rec cmd", PBMC_CMD_RECORD, last_cmd)
    cycles(10); rec_n = 1'b1;
    for (i = 0; i < 4 && op_stop !== 1'b1; i++) @(negedge ref_clk);
    `CHK("rec stop", 1'b1, op_stop)
    wait_idle();
  endtask
  task automatic t_fwd();
    fwd_n = 1'b0; cycles(10); fwd_n = 1'b1; wait_starts(n_start + 1); wait_idle();
    `CHK("fwd cmd", PBMC_CMD_FORWARD, last_cmd)
    `CHK("fwd ptr", 4'h2, ptr)
  endtask
  task automatic t_erase();
    int s;
    s = n_start;
    erase_n = 1'b0; cycles(10); erase_n = 1'b1; cycles(30);
    `CHK("erase mid", s, n_start)
    msg_cnt = 4'h3;
    erase_n = 1'b0; cycles(10); erase_n = 1'b1; wait_starts(s + 1); wait_idle();
    `CHK("erase one", PBMC_CMD_ERASE_ONE, last_cmd)
    erase_n = 1'b0; cycles(80); erase_n = 1'b1; wait_starts(s + 2); wait_idle();
    `CHK("erase all", PBMC_CMD_ERASE_ALL, last_cmd)
    `CHK("erase ptr", 4'h0, ptr)
  endtask
  task automatic t_path();
    pt_n = 1'b0; cycles(10);
    `CHK("pt on", 1'b1, pt_en)
    pt_n = 1'b1; cycles(10);
    `CHK("pt off", 1'b0, pt_en)
    serial = 1'b1; cfg = 12'h040; cycles(10);
    `CHK("cfg pt", 1'b1, pt_en)
    pt_n = 1'b0; cfg = 12'h000; cycles(10);
    `CHK("pin ignored", 1'b0, pt_en)
    cmd_done = 1'b1; cycles(1); cmd_done = 1'b0; cycles(3);
    `CHK("int set", 1'b1, oe)
    int_clr = 1'b1; cycles(1); int_clr = 1'b0; cycles(3);
    `CHK("int clr", 1'b0, oe)
  endtask
  task automatic t_loop();
    int s, i;
    s = n_start;
    play_n = 1'b0; wait_starts(s + 1); wait_starts(s + 2); cycles(1);
    `CHK("loop cmd", PBMC_CMD_PLAY, last_cmd)
    `CHK("loop ptr", 4'h1, ptr)
    play_n = 1'b1; cycles(10); play_n = 1'b0;
    for (i = 0; i < 20 && op_stop !== 1'b1; i++) @(negedge ref_clk);
    `CHK("play stop", 1'b1, op_stop)
    `CHK("rdy data", 1'b0, od)
    play_n = 1'b1; wait_idle();
    `CHK("stop idle", 1'b0, oe)
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    cycles(20); sys_rst = 1'b0; cycles(2);
    t_play(); t_rec(); t_fwd(); t_erase(); t_loop(); t_path();
    final_report();
  end
endmodule
`default_nettype wire
